// ### src/cwx_defines.vh
`ifndef CWX_DEFINES_VH
`define CWX_DEFINES_VH
`define CWX_CALL_HI 7'h76
`define CWX_CALL2_HI 4'hf
`define CWX_ZERO_HI 7'h35
`define CWX_KICK_WORD 16'h0004
`define CWX_RET_INC 21'h000004
`define CWX_Q1 2'h0
`define CWX_Q2 2'h1
`define CWX_Q3 2'h2
`define CWX_Q4 2'h3
`define CWX_STACK_DEPTH 5'h1f
`define CWX_ZERO_BIT 2
`define CWX_ACCESS_BANK 4'h0
`define CWX_PC_STEP 21'h000002
`define CWX_PC_RESET 21'h000000
`define CWX_NOP_WORD 16'hffff
`define CWX_CLEAR_DATA 8'h00
`define CWX_FLAG_SET 1'b1
`endif

// ### src/cwx_stack_mem.v
`timescale 1ns/1ps
`default_nettype none
module cwx_stack_mem (
  input wire clk,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [20:0] wr_data,
  input wire [4:0] rd_addr,
  output reg [20:0] rd_data
);
  reg [20:0] mem [0:31];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // cwx_stack_mem
`default_nettype wire

// ### src/cwx_core.v
`timescale 1ns/1ps
`default_nettype none
`include "cwx_defines.vh"
module cwx_core (
  input wire REF_CLK,
  input wire RST_N,
  input wire [15:0] INSTR,
  input wire [15:0] NEXT_WORD,
  input wire INSTR_VALID,
  input wire [7:0] ACCUMULATOR,
  input wire [7:0] FLAGS_IN,
  input wire [3:0] BANK_SELECT_REGISTER,
  input wire WDOG_TIMEOUT,
  input wire SLEEP_ENTRY,
  output reg [20:0] PC,
  output reg [20:0] STACK_TOP,
  output reg [4:0] STACK_PTR,
  output reg [7:0] ACC_SHADOW,
  output reg [7:0] FLAGS_SHADOW,
  output reg [3:0] BANK_SELECT_SHADOW,
  output reg [1:0] QPHASE,
  output reg FILE_WE,
  output reg [11:0] FILE_ADDR,
  output reg [7:0] FILE_WDATA,
  output reg ZERO_SET,
  output reg WDOG_CLEAR,
  output reg WDOG_EXPIRED_N,
  output reg SLEEP_FLAG_N,
  output reg BUSY
);
  localparam S_EXEC = 1'b0;
  localparam S_NOP = 1'b1;

  reg state;
  reg next_state;
  reg [15:0] cur;
  reg [7:0] lit_lo;
  wire [20:0] stack_rd;
  wire [20:0] ret_addr;
  wire [4:0] push_addr;
  wire in_exec;
  wire push;
  wire call_taken;
  wire kick_now;

  function is_call;
    input [15:0] w;
    begin
      is_call = (w[15:9] == `CWX_CALL_HI);
    end
  endfunction

  function is_call_tail;
    input [15:0] w;
    begin
      is_call_tail = (w[15:12] == `CWX_CALL2_HI);
    end
  endfunction

  function is_zero_file;
    input [15:0] w;
    begin
      is_zero_file = (w[15:9] == `CWX_ZERO_HI);
    end
  endfunction

  function is_kick;
    input [15:0] w;
    begin
      is_kick = (w == `CWX_KICK_WORD);
    end
  endfunction

  function [11:0] bank_addr;
    input [15:0] w;
    input [3:0] bank_select_register;
    begin
      // access bank when a=0 overrides bank select
      bank_addr = w[8] ? {bank_select_register, w[7:0]} : {`CWX_ACCESS_BANK, w[7:0]};
    end
  endfunction

  assign in_exec = (state == S_EXEC);
  assign ret_addr = PC + `CWX_RET_INC;
  assign push_addr = STACK_PTR + 5'h01;
  assign push = in_exec && (QPHASE == `CWX_Q3) && is_call(cur);
  assign call_taken = in_exec && (QPHASE == `CWX_Q4) && is_call(cur) && is_call_tail(NEXT_WORD);
  assign kick_now = in_exec && (QPHASE == `CWX_Q4) && is_kick(cur);

  // no pop here, so a wrapped stack silently overwrites the oldest entry
  cwx_stack_mem u_stack (
    .clk(REF_CLK),
    .wr_en(push),
    .wr_addr(push_addr),
    .wr_data(ret_addr),
    .rd_addr(STACK_PTR),
    .rd_data(stack_rd)
  );

  // quarter counter, four clocks per instruction cycle
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      QPHASE <= `CWX_Q1;
    end else begin
      QPHASE <= QPHASE + 2'h1;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      S_EXEC: begin
        if (call_taken) begin
          next_state = S_NOP;
        end
      end
      S_NOP: begin
        // refill cycle, words fetched here are dropped
        if (QPHASE == `CWX_Q4) begin
          next_state = S_EXEC;
        end
      end
      default: begin
        next_state = S_EXEC;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_EXEC;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUSY <= 1'b0;
    end else if (in_exec && QPHASE == `CWX_Q1) begin
      BUSY <= INSTR_VALID && is_call(INSTR);
    end else if (in_exec && QPHASE == `CWX_Q4 && !call_taken) begin
      // refused call: no refill cycle follows
      BUSY <= 1'b0;
    end else if (!in_exec && QPHASE == `CWX_Q4) begin
      BUSY <= 1'b0;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= `CWX_NOP_WORD;
      lit_lo <= 8'h00;
    end else if (in_exec) begin
      if (QPHASE == `CWX_Q1) begin
        // invalid fetch becomes a word that decodes to nothing
        cur <= INSTR_VALID ? INSTR : `CWX_NOP_WORD;
      end
      if (QPHASE == `CWX_Q2 && is_call(cur)) begin
        lit_lo <= cur[7:0];
      end
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PC <= `CWX_PC_RESET;
    end else if (call_taken) begin
      PC <= {NEXT_WORD[11:0], lit_lo, 1'b0};
    end else if (in_exec && QPHASE == `CWX_Q4) begin
      PC <= PC + `CWX_PC_STEP;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      STACK_PTR <= 5'h00;
      STACK_TOP <= 21'h000000;
    end else if (push) begin
      STACK_PTR <= push_addr;
      STACK_TOP <= ret_addr;
    end else if (!in_exec && QPHASE == `CWX_Q1) begin
      // reload from memory so the port shows the stored entry
      STACK_TOP <= stack_rd;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACC_SHADOW <= 8'h00;
      FLAGS_SHADOW <= 8'h00;
      BANK_SELECT_SHADOW <= 4'h0;
    end else if (push && cur[8]) begin
      ACC_SHADOW <= ACCUMULATOR;
      FLAGS_SHADOW <= FLAGS_IN;
      BANK_SELECT_SHADOW <= BANK_SELECT_REGISTER;
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FILE_WE <= 1'b0;
      FILE_ADDR <= 12'h000;
      FILE_WDATA <= 8'h00;
      ZERO_SET <= 1'b0;
    end else begin
      FILE_WE <= 1'b0;
      ZERO_SET <= 1'b0;
      if (in_exec && is_zero_file(cur)) begin
        case (QPHASE)
          `CWX_Q2: begin
            FILE_ADDR <= bank_addr(cur, BANK_SELECT_REGISTER);
          end
          `CWX_Q3: begin
            FILE_WDATA <= `CWX_CLEAR_DATA;
          end
          `CWX_Q4: begin
            FILE_WE <= 1'b1;
            ZERO_SET <= 1'b1;
          end
          default: begin
            FILE_WE <= 1'b0;
          end
        endcase
      end
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WDOG_CLEAR <= 1'b0;
      WDOG_EXPIRED_N <= `CWX_FLAG_SET;
      SLEEP_FLAG_N <= `CWX_FLAG_SET;
    end else begin
      WDOG_CLEAR <= kick_now;
      // timeout or sleep entry in the kick cycle wins, so no event is lost
      if (WDOG_TIMEOUT) begin
        WDOG_EXPIRED_N <= 1'b0;
      end else if (kick_now) begin
        WDOG_EXPIRED_N <= `CWX_FLAG_SET;
      end
      if (SLEEP_ENTRY) begin
        SLEEP_FLAG_N <= 1'b0;
      end else if (kick_now) begin
        SLEEP_FLAG_N <= `CWX_FLAG_SET;
      end
    end
  end
endmodule // cwx_core
`default_nettype wire

// ### bench/cwx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cwx_monitor (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [15:0] INSTR,
  input wire logic [15:0] NEXT_WORD,
  input wire logic INSTR_VALID,
  input wire logic WDOG_TIMEOUT,
  input wire logic SLEEP_ENTRY,
  input wire logic [1:0] QPHASE,
  input wire logic FILE_WE,
  input wire logic [7:0] FILE_WDATA,
  input wire logic ZERO_SET,
  input wire logic WDOG_CLEAR,
  input wire logic WDOG_EXPIRED_N,
  input wire logic SLEEP_FLAG_N,
  input wire logic BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // busy gate: words in the nop cycle are ignored
  sequence s_go; QPHASE == 2'h0 && INSTR_VALID && !BUSY; endsequence
  sequence s_call; s_go ##0 INSTR[15:9] == 7'h76; endsequence
  sequence s_tail; NEXT_WORD[15:12] == 4'hf; endsequence
  property p_zf; s_go ##0 INSTR[15:9] == 7'h35 |-> ##4 FILE_WE; endproperty
  a_zf: assert property (p_zf) else $error("clear late");
  property p_kk; s_go ##0 INSTR == 16'h0004 |-> ##4 WDOG_CLEAR; endproperty
  a_kk: assert property (p_kk) else $error("kick late");
  property p_cl; s_call ##3 s_tail |=> BUSY [*4] ##1 !BUSY; endproperty
  a_cl: assert property (p_cl) else $error("call short");
  property p_cb; s_call |=> BUSY [*3]; endproperty
  a_cb: assert property (p_cb) else $error("call busy");
  property p_cr; s_call ##3 !(NEXT_WORD[15:12] == 4'hf) |=> !BUSY; endproperty
  a_cr: assert property (p_cr) else $error("tail refused");
  property p_zd; FILE_WE |-> ZERO_SET && FILE_WDATA == 8'h00 && QPHASE == 2'h0; endproperty
  a_zd: assert property (p_zd) else $error("clear data");
  property p_zs; ZERO_SET |-> FILE_WE; endproperty
  a_zs: assert property (p_zs) else $error("zero alone");
  property p_fp; FILE_WE |=> !FILE_WE; endproperty
  a_fp: assert property (p_fp) else $error("write long");
  property p_wp; WDOG_CLEAR |=> !WDOG_CLEAR; endproperty
  a_wp: assert property (p_wp) else $error("kick long");
  property p_wf;
    WDOG_CLEAR && !$past(WDOG_TIMEOUT) && !$past(SLEEP_ENTRY) |-> WDOG_EXPIRED_N && SLEEP_FLAG_N && QPHASE == 2'h0;
  endproperty
  a_wf: assert property (p_wf) else $error("kick flags");
endmodule // cwx_monitor
bind cwx_core cwx_monitor mon (.REF_CLK, .RST_N, .INSTR, .NEXT_WORD, .INSTR_VALID, .WDOG_TIMEOUT, .SLEEP_ENTRY,
  .QPHASE, .FILE_WE, .FILE_WDATA,
  .ZERO_SET, .WDOG_CLEAR, .WDOG_EXPIRED_N, .SLEEP_FLAG_N, .BUSY);
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic REF_CLK = 0, RST_N = 0, INSTR_VALID = 0, WDOG_TIMEOUT = 0, SLEEP_ENTRY = 0;
  logic [15:0] INSTR = 0, NEXT_WORD = 0;
  logic [7:0] ACCUMULATOR = 8'h3c, FLAGS_IN = 8'h15;
  logic [3:0] BANK_SELECT_REGISTER = 4'h9;
  wire [20:0] PC, STACK_TOP;
  wire [7:0] ACC_SHADOW, FLAGS_SHADOW, FILE_WDATA;
  wire [3:0] BANK_SELECT_SHADOW;
  wire [11:0] FILE_ADDR;
  wire [4:0] STACK_PTR;
  wire [1:0] QPHASE;
  wire FILE_WE, ZERO_SET, WDOG_CLEAR, WDOG_EXPIRED_N, SLEEP_FLAG_N, BUSY;
  int failures = 0, check_count = 0, cyc = 0;
  cwx_core dut (.*);
  initial forever #25 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (++cyc == 1000) begin
    failures++;
    summarize();
  end
  task automatic chk(string n, logic [20:0] e, logic [20:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // returns at the negedge after the Q4 edge, while pulses stand
  task automatic op(logic [15:0] i, logic [15:0] w);
    @(negedge REF_CLK);
    while (QPHASE !== 2'h0 || BUSY !== 1'b0) @(negedge REF_CLK);
    INSTR = i;
    NEXT_WORD = w;
    INSTR_VALID = 1;
    @(negedge REF_CLK) INSTR_VALID = 0;
    repeat (3) @(negedge REF_CLK);
  endtask
  // pulls both status flags low through the timeout and sleep inputs
  task automatic drop_flags;
    @(negedge REF_CLK);
    WDOG_TIMEOUT = 1;
    SLEEP_ENTRY = 1;
    @(negedge REF_CLK);
    WDOG_TIMEOUT = 0;
    SLEEP_ENTRY = 0;
    chk("dropped", 21'h0, {19'h0, WDOG_EXPIRED_N, SLEEP_FLAG_N});
  endtask
  task t_call;
    op(16'hed45, 16'hf123);
    chk("pc", 21'h2468a, PC);
    ACCUMULATOR = 8'h77;
    op(16'hecde, 16'hfabc);
    chk("pc", 21'h1579bc, PC);
    chk("top", 21'h2468e, STACK_TOP);
    chk("shadows", 21'h093c15, {1'b0, BANK_SELECT_SHADOW, ACC_SHADOW, FLAGS_SHADOW});
    chk("busy", 21'h1, {20'h0, BUSY});
    chk("sp", 21'h2, {16'h0, STACK_PTR});
    $display("call test done");
  endtask
  task t_refuse;
    repeat (2) @(negedge REF_CLK);
    chk("stored top", 21'h2468e, STACK_TOP);
    op(16'hec00, 16'h0123);
    chk("refused pc", 21'h1579be, PC);
    chk("refused busy", 21'h0, {20'h0, BUSY});
    chk("refused top", 21'h1579c0, STACK_TOP);
    $display("refuse test done");
  endtask
  task t_zero;
    op(16'h6a5a, 16'h0000);
    chk("access", 21'h105a00, {FILE_WE, FILE_ADDR, FILE_WDATA});
    chk("zero flag", 21'h1, {20'h0, ZERO_SET});
    op(16'h6b33, 16'h0000);
    chk("banked", 21'h193300, {FILE_WE, FILE_ADDR, FILE_WDATA});
    $display("clear test done");
  endtask
  task t_kick;
    drop_flags();
    op(16'h0004, 16'h0000);
    chk("kick", 21'h7, {18'h0, WDOG_CLEAR, WDOG_EXPIRED_N, SLEEP_FLAG_N});
    chk("kick zero", 21'h0, {19'h0, ZERO_SET, FILE_WE});
    drop_flags();
    op(16'h0005, 16'h0000);
    chk("other", 21'h0, {18'h0, WDOG_CLEAR, WDOG_EXPIRED_N, SLEEP_FLAG_N});
    $display("kick test done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge REF_CLK);
    RST_N = 1;
    t_call();
    t_refuse();
    t_zero();
    t_kick();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
